//--- isc_regs.svh
`ifndef ISC_REGS_SVH
`define ISC_REGS_SVH
`define ISC_NREG 137
`define ISC_A_ID 8'h00
`define ISC_A_REV 8'h01
`define ISC_A_CLKDIV 8'h05
`define ISC_A_PWRRST 8'h06
`define ISC_A_SLAVE 8'h07
`define ISC_A_OPCTL 8'h09
`define ISC_A_VIDCFG 8'h10
`define ISC_A_VERTICAL_SCAN_CONFIG 8'h11
`define ISC_A_HORIZONTAL_SCAN_CONFIG 8'h13
`define ISC_A_INTCFG 8'h15
`define ISC_A_ROWS 8'h19
`define ISC_A_ROWE 8'h1a
`define ISC_A_ROWL 8'h1b
`define ISC_A_COLS 8'h1c
`define ISC_A_COLE 8'h1d
`define ISC_A_COLL 8'h1e
`define ISC_A_FDLY_H 8'h20
`define ISC_A_FDLY_L 8'h21
`define ISC_A_RDLY_H 8'h22
`define ISC_A_RDLY_L 8'h23
`define ISC_A_EXP_H 8'h24
`define ISC_A_EXP_L 8'h25
`define ISC_A_SNAP 8'h30
`define ISC_A_SNAP_H 8'h31
`define ISC_A_SNAP_L 8'h32
`define ISC_A_BLK_CFG 8'h40
`define ISC_A_BLK_GOAL 8'h41
`define ISC_A_GAIN0 8'h42
`define ISC_A_GAIN3 8'h45
`define ISC_A_BIAS0 8'h46
`define ISC_A_BIAS3 8'h49
`define ISC_A_CMAP 8'h4a
`define ISC_A_FSYNC 8'h50
`define ISC_A_LSYNC 8'h51
`define ISC_A_VBUS_A 8'h52
`define ISC_A_VBUS_B 8'h53
`define ISC_A_VBUS_C 8'h54
`define ISC_A_VBUS_D 8'h55
`define ISC_A_INIT1 8'h80
`define ISC_A_PIXBIAS 8'h83
`define ISC_A_PWRCTL 8'h85
`define ISC_A_INIT2 8'h88
`define ISC_R_SLAVE 8'haa
`define ISC_R_OPCTL 8'h02
`define ISC_R_VIDCFG 8'h01
`define ISC_R_SCAN 8'h04
`define ISC_R_INTCFG 8'h08
`define ISC_R_ROWE 8'h80
`define ISC_R_LOWS 8'h23
`define ISC_R_COLE 8'ha0
`define ISC_R_DLY_L 8'h08
`define ISC_R_SNAP 8'h07
`define ISC_R_SNAP_H 8'h1f
`define ISC_R_SNAP_L 8'h7f
`define ISC_R_BLK_CFG 8'h07
`define ISC_R_BLK_GOAL 8'h10
`define ISC_R_CMAP 8'h1b
`define ISC_R_SYNC 8'h08
`define ISC_R_VBUS_B 8'h0c
`define ISC_R_VBUS_C 8'hf0
`define ISC_R_PIXBIAS 8'h1e
`define ISC_R_PWRCTL 8'h81
`define ISC_M_CLKDIV 8'h06
`define ISC_M_PWRRST 8'h01
`define ISC_M_OPCTL 8'h0e
`define ISC_M_BIT0 8'h01
`define ISC_M_SCAN 8'h07
`define ISC_M_INTCFG 8'h08
`define ISC_M_ROWL 8'h3f
`define ISC_M_COLL 8'h27
`define ISC_M_7BIT 8'h7f
`define ISC_M_DLY_L 8'h1f
`define ISC_M_EXP_H 8'h0f
`define ISC_M_SNAP 8'h3f
`define ISC_M_BLK_CFG 8'h0f
`define ISC_B_SENRST 1
`define ISC_B_FSMRST 0
`define ISC_B_DIMGAIN 3
`define ISC_B_SYNCDRV 2
`define ISC_B_DIR 2
`define ISC_B_SUB 1
`define ISC_B_AVG 0
`define ISC_B_PARTIAL 3
`define ISC_P_CTRL 12'h000
`define ISC_P_TARGET 12'h004
`define ISC_P_WDATA 12'h008
`define ISC_P_STATUS 12'h00c
`endif

//--- isc_pkg.sv
package isc_pkg;
  typedef logic [7:0] isc_byte_t;
  typedef enum logic [1:0] {ISC_H_IDLE, ISC_H_REQ, ISC_H_DROP} isc_hst_state_t;
endpackage : isc_pkg

//--- isc_link_if.sv
`timescale 1ns/1ps
interface isc_link_if;
  logic req;
  logic [6:0] sla;
  logic rnw;
  logic seq;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic nak;
  logic [7:0] rdata;
  modport dev (input req, sla, rnw, seq, addr, wdata, output ack, nak, rdata);
  modport hst (output req, sla, rnw, seq, addr, wdata, input ack, nak, rdata);
endinterface : isc_link_if

//--- isc_sensor_regs.sv
`timescale 1ns/1ps
`include "isc_regs.svh"
module isc_sensor_regs
  import isc_pkg::*;
#(
  parameter logic [7:0] DEVICE_ID = 8'h3c, // arbitrary value
  parameter logic [7:0] SILICON_REV = 8'h01 // arbitrary value
)(
  input wire logic I_CLK,
  input wire logic I_RSTN,
  isc_link_if.dev link,
  input wire logic I_FRAME_UPDATE,
  output logic O_HCLK_TICK,
  output logic O_SENSOR_RESET,
  output logic O_FSM_RESET,
  output logic O_POWER_DOWN,
  output logic O_DIM_SCENE_GAIN,
  output logic O_SYNC_DRIVER_SELECT,
  output logic O_COLOR_MODE,
  output logic O_VERTICAL_READOUT_DIRECTION,
  output logic O_VERTICAL_SUBSAMPLE,
  output logic O_VERTICAL_MEAN_ENABLE,
  output logic O_HORIZONTAL_READOUT_DIRECTION,
  output logic O_HORIZONTAL_SUBSAMPLE,
  output logic O_HORIZONTAL_MEAN_ENABLE,
  output logic O_PARTIAL_FRAME_EXPOSURE_ENABLE,
  output logic [10:0] O_WINDOW_FIRST_ROW,
  output logic [10:0] O_WINDOW_LAST_ROW,
  output logic [10:0] O_WINDOW_FIRST_COLUMN,
  output logic [10:0] O_WINDOW_LAST_COLUMN
);

  function automatic isc_byte_t rst_val(input isc_byte_t a);
    unique case (a)
      `ISC_A_SLAVE: rst_val = `ISC_R_SLAVE;
      `ISC_A_OPCTL: rst_val = `ISC_R_OPCTL;
      `ISC_A_VIDCFG: rst_val = `ISC_R_VIDCFG;
      `ISC_A_VERTICAL_SCAN_CONFIG, `ISC_A_HORIZONTAL_SCAN_CONFIG: rst_val = `ISC_R_SCAN;
      `ISC_A_INTCFG: rst_val = `ISC_R_INTCFG;
      `ISC_A_ROWE: rst_val = `ISC_R_ROWE;
      `ISC_A_ROWL, `ISC_A_COLL: rst_val = `ISC_R_LOWS;
      `ISC_A_COLE: rst_val = `ISC_R_COLE;
      `ISC_A_FDLY_L, `ISC_A_RDLY_L: rst_val = `ISC_R_DLY_L;
      `ISC_A_SNAP: rst_val = `ISC_R_SNAP;
      `ISC_A_SNAP_H: rst_val = `ISC_R_SNAP_H;
      `ISC_A_SNAP_L: rst_val = `ISC_R_SNAP_L;
      `ISC_A_BLK_CFG: rst_val = `ISC_R_BLK_CFG;
      `ISC_A_BLK_GOAL: rst_val = `ISC_R_BLK_GOAL;
      `ISC_A_CMAP: rst_val = `ISC_R_CMAP;
      `ISC_A_FSYNC, `ISC_A_LSYNC: rst_val = `ISC_R_SYNC;
      `ISC_A_VBUS_B: rst_val = `ISC_R_VBUS_B;
      `ISC_A_VBUS_C: rst_val = `ISC_R_VBUS_C;
      `ISC_A_PIXBIAS: rst_val = `ISC_R_PIXBIAS;
      `ISC_A_PWRCTL: rst_val = `ISC_R_PWRCTL;
      default: rst_val = 8'h00;
    endcase
  endfunction : rst_val

  // writable bits; zero mask marks a hole or a read-only location
  function automatic isc_byte_t wr_mask(input isc_byte_t a);
    unique case (a)
      `ISC_A_CLKDIV: wr_mask = `ISC_M_CLKDIV;
      `ISC_A_PWRRST: wr_mask = `ISC_M_PWRRST;
      `ISC_A_OPCTL: wr_mask = `ISC_M_OPCTL;
      `ISC_A_VIDCFG: wr_mask = `ISC_M_BIT0;
      `ISC_A_VERTICAL_SCAN_CONFIG, `ISC_A_HORIZONTAL_SCAN_CONFIG: wr_mask = `ISC_M_SCAN;
      `ISC_A_INTCFG: wr_mask = `ISC_M_INTCFG;
      `ISC_A_ROWL: wr_mask = `ISC_M_ROWL;
      `ISC_A_COLL: wr_mask = `ISC_M_COLL;
      `ISC_A_FDLY_L, `ISC_A_EXP_L, `ISC_A_SNAP_L: wr_mask = `ISC_M_7BIT;
      `ISC_A_RDLY_L: wr_mask = `ISC_M_DLY_L;
      `ISC_A_EXP_H: wr_mask = `ISC_M_EXP_H;
      `ISC_A_SNAP: wr_mask = `ISC_M_SNAP;
      `ISC_A_BLK_CFG: wr_mask = `ISC_M_BLK_CFG;
      `ISC_A_SLAVE, `ISC_A_ROWS, `ISC_A_ROWE, `ISC_A_COLS, `ISC_A_COLE,
      `ISC_A_FDLY_H, `ISC_A_RDLY_H, `ISC_A_SNAP_H, `ISC_A_BLK_GOAL,
      `ISC_A_BIAS0, 8'h47, 8'h48, `ISC_A_BIAS3, `ISC_A_CMAP,
      `ISC_A_FSYNC, `ISC_A_LSYNC, `ISC_A_VBUS_A, `ISC_A_VBUS_B,
      `ISC_A_VBUS_C, `ISC_A_VBUS_D, `ISC_A_INIT1, `ISC_A_PIXBIAS,
      `ISC_A_PWRCTL, `ISC_A_INIT2: wr_mask = 8'hff;
      default: wr_mask = (a >= `ISC_A_GAIN0 && a <= `ISC_A_GAIN3) ? `ISC_M_7BIT : 8'h00;
    endcase
  endfunction : wr_mask

  function automatic logic is_dbuf(input isc_byte_t a);
    is_dbuf = (a == `ISC_A_VERTICAL_SCAN_CONFIG) || (a == `ISC_A_HORIZONTAL_SCAN_CONFIG) || (a == `ISC_A_INTCFG)
           || (a >= `ISC_A_ROWS && a <= `ISC_A_COLL)
           || (a >= `ISC_A_FDLY_H && a <= `ISC_A_EXP_L)
           || (a >= `ISC_A_SNAP && a <= `ISC_A_SNAP_L);
  endfunction : is_dbuf

  isc_byte_t sh_r [0:`ISC_NREG-1];
  isc_byte_t act_r [0:`ISC_NREG-1];
  isc_byte_t ptr_r;
  isc_byte_t rdata_r;
  isc_byte_t acc_addr;
  logic resp_r;
  logic ack_r;
  logic nak_r;
  logic sen_rst_r;
  logic fsm_rst_r;
  logic [2:0] div_cnt_r;
  logic [2:0] div_last;
  logic take;
  logic accept;
  logic wr_en;
  logic burst_en;

  assign burst_en = sh_r[`ISC_A_SLAVE][0];
  // one action per request; the flag holds off the request's second cycle
  assign take = link.req && !resp_r;
  assign acc_addr = link.seq ? ptr_r : link.addr;
  assign accept = (link.sla == sh_r[`ISC_A_SLAVE][7:1])
               && !(link.seq && (link.rnw || !burst_en));
  assign wr_en = take && accept && !link.rnw;

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      resp_r <= 1'b0;
      ack_r <= 1'b0;
      nak_r <= 1'b0;
      rdata_r <= 8'h00;
      ptr_r <= 8'h00;
    end
    else
    begin
      resp_r <= take;
      ack_r <= take && accept;
      nak_r <= take && !accept;
      if (take && accept)
      begin
        ptr_r <= acc_addr + 8'h01;
        if (acc_addr == `ISC_A_ID)
          rdata_r <= DEVICE_ID;
        else if (acc_addr == `ISC_A_REV)
          rdata_r <= SILICON_REV;
        else if (acc_addr < 8'(`ISC_NREG))
          rdata_r <= sh_r[acc_addr] & wr_mask(acc_addr);
        else
          rdata_r <= 8'h00;
      end
    end
  end

  assign link.ack = ack_r;
  assign link.nak = nak_r;
  assign link.rdata = rdata_r;

  // self-clearing strobes: never stored, so they read back as zero
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      sen_rst_r <= 1'b0;
      fsm_rst_r <= 1'b0;
    end
    else
    begin
      sen_rst_r <= wr_en && acc_addr == `ISC_A_PWRRST && link.wdata[`ISC_B_SENRST];
      fsm_rst_r <= wr_en && acc_addr == `ISC_A_OPCTL && link.wdata[`ISC_B_FSMRST];
    end
  end

  // shadow and live copies; a full sensor reset reloads both
  generate
    for (genvar g = 0; g < `ISC_NREG; g++)
    begin : g_reg
      localparam isc_byte_t AD = 8'(g);
      // reset value fixed at elaboration so the reset branch loads a constant
      localparam isc_byte_t RV = rst_val(AD);
      always_ff @(posedge I_CLK or negedge I_RSTN)
      begin
        if (!I_RSTN)
          sh_r[g] <= RV;
        else if (sen_rst_r)
          sh_r[g] <= RV;
        else if (wr_en && acc_addr == AD)
          sh_r[g] <= (link.wdata & wr_mask(AD)) | (sh_r[g] & ~wr_mask(AD));
      end
      always_ff @(posedge I_CLK or negedge I_RSTN)
      begin
        if (!I_RSTN)
          act_r[g] <= RV;
        else if (sen_rst_r)
          act_r[g] <= RV;
        else if (!is_dbuf(AD) || I_FRAME_UPDATE)
          act_r[g] <= sh_r[g];
      end
    end
  endgenerate

  // divider field 0..3 means divide by 1, 2, 4, 6
  always_comb
  begin
    unique case (act_r[`ISC_A_CLKDIV][2:1])
      2'd0: div_last = 3'd0;
      2'd1: div_last = 3'd1;
      2'd2: div_last = 3'd3;
      2'd3: div_last = 3'd5;
    endcase
  end

  // counter frozen in power-down so no tick escapes
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      div_cnt_r <= 3'd0;
    else if (sen_rst_r)
      div_cnt_r <= 3'd0;
    else if (!O_POWER_DOWN)
      div_cnt_r <= (div_cnt_r >= div_last) ? 3'd0 : div_cnt_r + 3'd1;
  end

  assign O_POWER_DOWN = act_r[`ISC_A_PWRRST][0];
  assign O_HCLK_TICK = !O_POWER_DOWN && (div_cnt_r >= div_last);
  assign O_SENSOR_RESET = sen_rst_r;
  assign O_FSM_RESET = fsm_rst_r;
  assign O_DIM_SCENE_GAIN = act_r[`ISC_A_OPCTL][`ISC_B_DIMGAIN];
  assign O_SYNC_DRIVER_SELECT = act_r[`ISC_A_OPCTL][`ISC_B_SYNCDRV];
  assign O_COLOR_MODE = act_r[`ISC_A_VIDCFG][0];
  assign O_VERTICAL_READOUT_DIRECTION = act_r[`ISC_A_VERTICAL_SCAN_CONFIG][`ISC_B_DIR];
  assign O_VERTICAL_MEAN_ENABLE = act_r[`ISC_A_VERTICAL_SCAN_CONFIG][`ISC_B_AVG];
  assign O_VERTICAL_SUBSAMPLE = act_r[`ISC_A_VERTICAL_SCAN_CONFIG][`ISC_B_SUB]
                              | act_r[`ISC_A_VERTICAL_SCAN_CONFIG][`ISC_B_AVG];
  assign O_HORIZONTAL_READOUT_DIRECTION = act_r[`ISC_A_HORIZONTAL_SCAN_CONFIG][`ISC_B_DIR];
  assign O_HORIZONTAL_MEAN_ENABLE = act_r[`ISC_A_HORIZONTAL_SCAN_CONFIG][`ISC_B_AVG];
  assign O_HORIZONTAL_SUBSAMPLE = act_r[`ISC_A_HORIZONTAL_SCAN_CONFIG][`ISC_B_SUB]
                                | act_r[`ISC_A_HORIZONTAL_SCAN_CONFIG][`ISC_B_AVG];
  assign O_PARTIAL_FRAME_EXPOSURE_ENABLE = act_r[`ISC_A_INTCFG][`ISC_B_PARTIAL];
  assign O_WINDOW_FIRST_ROW = {act_r[`ISC_A_ROWS], act_r[`ISC_A_ROWL][5:3]};
  assign O_WINDOW_LAST_ROW = {act_r[`ISC_A_ROWE], act_r[`ISC_A_ROWL][2:0]};
  // first-column bits 1:0 are hard zero in the array decoder
  assign O_WINDOW_FIRST_COLUMN = {act_r[`ISC_A_COLS], act_r[`ISC_A_COLL][5], 2'b00};
  assign O_WINDOW_LAST_COLUMN = {act_r[`ISC_A_COLE], act_r[`ISC_A_COLL][2:0]};

endmodule : isc_sensor_regs

//--- isc_host_ctrl.sv
`timescale 1ns/1ps
`include "isc_regs.svh"
module isc_host_ctrl
  import isc_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  isc_link_if.hst link
);

  isc_hst_state_t state_r;
  logic [6:0] sla_r;
  isc_byte_t addr_r;
  isc_byte_t wdata_r;
  isc_byte_t rdata_r;
  logic rnw_r;
  logic seq_r;
  logic done_r;
  logic nak_r;
  logic [31:0] prdata_r;
  logic apb_wr;
  logic apb_rd;
  logic mapped;
  logic go;

  assign mapped = I_PADDR == `ISC_P_CTRL || I_PADDR == `ISC_P_TARGET
               || I_PADDR == `ISC_P_WDATA || I_PADDR == `ISC_P_STATUS;
  assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE && mapped;
  assign apb_rd = I_PSEL && !I_PENABLE && !I_PWRITE;
  // commands while busy are dropped; status shows busy
  assign go = apb_wr && I_PADDR == `ISC_P_CTRL && I_PWDATA[0] && state_r == ISC_H_IDLE;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
  assign O_PRDATA = prdata_r;

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      sla_r <= 7'h00;
      addr_r <= 8'h00;
      wdata_r <= 8'h00;
      rnw_r <= 1'b0;
      seq_r <= 1'b0;
    end
    else
    begin
      if (apb_wr && I_PADDR == `ISC_P_TARGET && state_r == ISC_H_IDLE)
      begin
        sla_r <= I_PWDATA[14:8];
        addr_r <= I_PWDATA[7:0];
      end
      if (apb_wr && I_PADDR == `ISC_P_WDATA && state_r == ISC_H_IDLE)
        wdata_r <= I_PWDATA[7:0];
      if (go)
      begin
        rnw_r <= I_PWDATA[1];
        seq_r <= I_PWDATA[2];
      end
    end
  end

  // read data is latched in setup so it stands through the access phase
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      prdata_r <= 32'h0000_0000;
    else if (apb_rd)
    begin
      if (I_PADDR == `ISC_P_TARGET)
        prdata_r <= {17'h0, sla_r, addr_r};
      else if (I_PADDR == `ISC_P_WDATA)
        prdata_r <= {24'h0, wdata_r};
      else if (I_PADDR == `ISC_P_STATUS)
        prdata_r <= {16'h0, rdata_r, 5'h0, nak_r, done_r, state_r != ISC_H_IDLE};
      else
        prdata_r <= 32'h0000_0000;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      state_r <= ISC_H_IDLE;
      done_r <= 1'b0;
      nak_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      unique case (state_r)
        ISC_H_IDLE:
          if (go)
          begin
            state_r <= ISC_H_REQ;
            done_r <= 1'b0;
            nak_r <= 1'b0;
          end
        ISC_H_REQ:
          if (link.ack || link.nak)
          begin
            state_r <= ISC_H_DROP;
            done_r <= 1'b1;
            nak_r <= link.nak;
            if (link.ack && rnw_r)
              rdata_r <= link.rdata;
          end
        // one idle cycle lets the device's answer flag fall
        ISC_H_DROP:
          state_r <= ISC_H_IDLE;
      endcase
    end
  end

  // software clears the colour bit for mono
  assign link.req = state_r == ISC_H_REQ;
  assign link.sla = sla_r;
  assign link.rnw = rnw_r;
  assign link.seq = seq_r;
  assign link.addr = addr_r;
  assign link.wdata = wdata_r;

endmodule : isc_host_ctrl

//--- isc_link_monitor.sv
`timescale 1ns/1ps
module isc_link_monitor
#(
  parameter logic [7:0] DEVICE_ID = 8'h3c,
  parameter logic [7:0] SILICON_REV = 8'h01
)(
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic req,
  input wire logic [6:0] sla,
  input wire logic rnw,
  input wire logic seq,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic nak,
  input wire logic [7:0] rdata
);
  logic [6:0] sla_r;
  logic burst_r;
  logic wr_ok;
  logic rd_ok;
  assign wr_ok = ack && !rnw && !seq;
  assign rd_ok = ack && rnw && !seq;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RSTN);
  // mirror of the slave setup so that refusals can be predicted
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      sla_r <= 7'h55;
      burst_r <= 1'b0;
    end
    else if (wr_ok && addr == 8'h07)
    begin
      sla_r <= wdata[7:1];
      burst_r <= wdata[0];
    end
    else if (wr_ok && addr == 8'h06 && wdata[1])
    begin
      sla_r <= 7'h55;
      burst_r <= 1'b0;
    end
  end
  a_answer_pulse: assert property ($rose(req) |=> (ack ^ nak) ##1 !(ack || nak))
    else $error("link answer missing or not a single pulse");
  a_foreign_nak: assert property ($rose(req) && sla != sla_r |=> nak)
    else $error("foreign slave address not refused");
  a_own_ack: assert property ($rose(req) && sla == sla_r && !seq |=> ack)
    else $error("own slave address refused");
  a_seq_no_burst: assert property ($rose(req) && seq && !burst_r |=> nak)
    else $error("burst beat accepted with burst off");
  a_seq_read_nak: assert property ($rose(req) && seq && rnw |=> nak)
    else $error("burst read not refused");
  a_burst_ok: assert property ($rose(req) && seq && burst_r && !rnw && sla == sla_r |=> ack)
    else $error("burst beat refused with burst on");
  a_ident_fixed: assert property (rd_ok && addr == 8'h00 |-> rdata == DEVICE_ID)
    else $error("identifier changed");
  a_rev_fixed: assert property (rd_ok && addr == 8'h01 |-> rdata == SILICON_REV)
    else $error("revision changed");
  a_reserved_zero: assert property (rd_ok && addr inside {[8'h02:8'h04], 8'h08, [8'h0a:8'h0f],
    8'h12, 8'h14, [8'h16:8'h18], 8'h1f, [8'h26:8'h2f], [8'h56:8'h7f], [8'h89:8'hff]}
    |-> rdata == 8'h00)
    else $error("reserved location not zero");
  a_selfclr_zero: assert property (rd_ok && addr == 8'h09 |-> !rdata[0])
    else $error("timing reset bit reads back set");
endmodule : isc_link_monitor

//--- image_sensor_control_registers_tb.sv
`timescale 1ns/1ps
`include "isc_regs.svh"
module image_sensor_control_registers_tb
  import isc_pkg::*;
;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, fu, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st, rd;
  logic tick, srst, frst, pd, dim, syn, col, vd, vs, vm, hd, hs, hm, pf;
  logic [10:0] r0, r1, c0, c1;
  logic [6:0] sla = 7'h55;
  isc_byte_t rb;
  int failures = 0, n_checks = 0, n_srst = 0, n_frst = 0, cnt;
  isc_byte_t ra_t [18] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h09, 8'h10, 8'h11,
    8'h12, 8'h13, 8'h15, 8'h1a, 8'h1b, 8'h1d, 8'h1e, 8'h30, 8'h90};
  isc_byte_t rv_t [18] = '{8'h3c, 8'h01, 8'h00, 8'h00, 8'h00, 8'haa, 8'h02, 8'h01, 8'h04,
    8'h00, 8'h04, 8'h08, 8'h80, 8'h23, 8'ha0, 8'h23, 8'h07, 8'h00};
  isc_link_if link_bus();
  isc_host_ctrl u_isc_host_ctrl (.I_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .link(link_bus.hst));
  isc_sensor_regs u_isc_sensor_regs (.I_CLK(clk), .I_RSTN(rstn), .link(link_bus.dev),
    .I_FRAME_UPDATE(fu), .O_HCLK_TICK(tick), .O_SENSOR_RESET(srst), .O_FSM_RESET(frst),
    .O_POWER_DOWN(pd), .O_DIM_SCENE_GAIN(dim), .O_SYNC_DRIVER_SELECT(syn), .O_COLOR_MODE(col),
    .O_VERTICAL_READOUT_DIRECTION(vd), .O_VERTICAL_SUBSAMPLE(vs), .O_VERTICAL_MEAN_ENABLE(vm),
    .O_HORIZONTAL_READOUT_DIRECTION(hd), .O_HORIZONTAL_SUBSAMPLE(hs),
    .O_HORIZONTAL_MEAN_ENABLE(hm), .O_PARTIAL_FRAME_EXPOSURE_ENABLE(pf),
    .O_WINDOW_FIRST_ROW(r0), .O_WINDOW_LAST_ROW(r1), .O_WINDOW_FIRST_COLUMN(c0),
    .O_WINDOW_LAST_COLUMN(c1));
  isc_link_monitor u_isc_link_monitor (.I_CLK(clk), .I_RSTN(rstn), .req(link_bus.req),
    .sla(link_bus.sla), .rnw(link_bus.rnw), .seq(link_bus.seq), .addr(link_bus.addr),
    .wdata(link_bus.wdata), .ack(link_bus.ack), .nak(link_bus.nak), .rdata(link_bus.rdata));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    n_srst += int'(srst === 1'b1);
    n_frst += int'(frst === 1'b1);
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] d, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // no wait limit here: only the watchdog ends a hung access
    do
      @(posedge clk);
    while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // cmd bit0 go, bit1 read, bit2 burst beat; status polled until done and idle
  task automatic dev_op(input logic [6:0] s, input isc_byte_t ra, input isc_byte_t wd,
    input logic [2:0] cmd);
    apb(1'b1, `ISC_P_TARGET, {17'h0, s, ra}, rd, err);
    apb(1'b1, `ISC_P_WDATA, {24'h0, wd}, rd, err);
    apb(1'b1, `ISC_P_CTRL, {29'h0, cmd}, rd, err);
    do
      apb(1'b0, `ISC_P_STATUS, 32'h0, st, err);
    while (st[1:0] !== 2'b10);
  endtask : dev_op

  task automatic dwr(input isc_byte_t ra, input isc_byte_t wd);
    dev_op(sla, ra, wd, 3'b001);
  endtask : dwr

  task automatic drd(input isc_byte_t ra, input isc_byte_t exp);
    dev_op(sla, ra, 8'h00, 3'b011);
    chk($sformatf("register %h", ra), 64'(exp), 64'(st[15:8]));
  endtask : drd

  task automatic ticks(input int exp);
    repeat (2) @(posedge clk);
    cnt = 0;
    repeat (24) @(posedge clk) cnt += int'(tick === 1'b1);
    chk("clock ticks in 24 cycles", 64'(exp), 64'(cnt));
  endtask : ticks

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end

  initial
  begin
    rstn = 1'b0;
    {psel, penable, pwrite, fu, paddr, pwdata} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 18; i++)
      drd(ra_t[i], rv_t[i]);
    chk("window at reset", 64'({r0, r1, c0, c1}),
      64'({11'h004, 11'h403, 11'h004, 11'h503}));
    dwr(8'h00, 8'hff);
    dwr(8'h01, 8'h5a);
    drd(8'h00, 8'h3c);
    drd(8'h01, 8'h01);
    dwr(8'h02, 8'h5a);
    drd(8'h02, 8'h00);
    dwr(8'h09, 8'hf6);
    drd(8'h09, 8'h06);
    chk("gain and sync", 64'({dim, syn}), 64'h1);
    dwr(8'h09, 8'h0b);
    drd(8'h09, 8'h0a);
    chk("gain, sync, timing resets", 64'({dim, syn, n_frst[1:0]}), 64'h9);
    apb(1'b0, 12'h010, 32'h0, rd, err);
    chk("unmapped host read", {rd, 31'h0, err}, 64'h1);
    dwr(8'h10, 8'h00);
    chk("mono timing", 64'(col), 64'h0);
    dwr(8'h10, 8'h01);
    chk("colour timing", 64'(col), 64'h1);
    for (int k = 0; k < 4; k++)
    begin
      dwr(8'h05, isc_byte_t'(k << 1));
      ticks(24 / (k == 0 ? 1 : 2 * k));
    end
    dwr(8'h06, 8'h01);
    chk("power down", 64'(pd), 64'h1);
    ticks(0);
    dwr(8'h06, 8'h00);
    ticks(4);
    foreach (ra_t[i])
      if (ra_t[i] inside {8'h11, 8'h13, 8'h1a, 8'h1b, 8'h1d, 8'h1e})
        dwr(ra_t[i], ra_t[i] == 8'h11 ? 8'h03 : ra_t[i] == 8'h13 ? 8'h01 : 8'h25);
    dwr(8'h15, 8'h00);
    dwr(8'h19, 8'h12);
    dwr(8'h1a, 8'h34);
    dwr(8'h1c, 8'h56);
    dwr(8'h1d, 8'h78);
    chk("scan before update", 64'({vd, vs, vm, hd, hs, hm, pf}), 64'h49);
    @(posedge clk);
    fu <= 1'b1;
    @(posedge clk);
    fu <= 1'b0;
    repeat (2) @(posedge clk);
    chk("scan after update", 64'({vd, vs, vm, hd, hs, hm, pf}), 64'h36);
    chk("window", 64'({r0, r1, c0, c1}),
      64'({11'h094, 11'h1a5, 11'h2b4, 11'h3c5}));
    dwr(8'h07, 8'h66);
    sla = 7'h33;
    dev_op(7'h55, 8'h09, 8'h00, 3'b011);
    chk("foreign address refused", 64'(st[2]), 64'h1);
    drd(8'h07, 8'h66);
    dev_op(sla, 8'h00, 8'h11, 3'b101);
    chk("burst while off", 64'(st[2]), 64'h1);
    dwr(8'h07, 8'h67);
    dwr(8'h41, 8'h21);
    dev_op(sla, 8'h00, 8'h13, 3'b101);
    chk("burst beat", 64'(st[2]), 64'h0);
    drd(8'h42, 8'h13);
    dev_op(sla, 8'h00, 8'h00, 3'b111);
    chk("burst read refused", 64'(st[2]), 64'h1);
    dwr(8'h06, 8'h02);
    sla = 7'h55;
    chk("sensor reset pulses", 64'({dim, n_srst[1:0]}), 64'h1);
    drd(8'h07, 8'haa);
    drd(8'h06, 8'h00);
    results();
  end
endmodule : image_sensor_control_registers_tb
